// [common/srx_pkg.sv]
// Constants and types shared by the link receiver control register slice.
// Assumes one clock domain; nothing is imported, users write srx_pkg::name.
package srx_pkg;
    // Register offsets
    localparam logic [7:0] EQ_READOUT_ADDR = 8'h3b; // Equalizer state readout
    localparam logic [7:0] FAULT_THR_ADDR = 8'h41; // Link fault threshold
    localparam logic [7:0] BACK_CFG_ADDR = 8'h43; // Back-channel config
    localparam logic [7:0] EQ_MANUAL_ADDR = 8'h44; // Equalizer manual setting
    localparam logic [7:0] EQ_FLOOR_ADDR = 8'h45; // Equalizer floor config
    localparam logic [7:0] LT_SOURCE_ADDR = 8'h52; // Loop-through source
    localparam logic [7:0] LT_DRIVER_ADDR = 8'h56; // Loop-through driver on
    // Reset values
    localparam logic [7:0] FAULT_THR_RST = 8'h03; // Threshold 3, count off
    localparam logic [7:0] BACK_CFG_RST = 8'h00; // Normal frame GPIO
    localparam logic [7:0] EQ_MANUAL_RST = 8'h60; // Upper bits 3
    localparam logic [7:0] EQ_FLOOR_RST = 8'h88; // Floor 8
    localparam logic [7:0] LT_SOURCE_RST = 8'h00; // First input
    localparam logic [7:0] LT_DRIVER_RST = 8'h00; // Driver off
    // Field positions
    localparam int THR_LSB = 0; // Threshold low bit
    localparam int THR_W = 4; // Threshold width
    localparam int CNT_EN_BIT = 4; // Error count enable
    localparam int KIND_LSB = 0; // Back-channel kind low bit
    localparam int KIND_W = 3; // Back-channel kind width
    localparam int POL_BIT = 3; // Serial clock polarity
    localparam int MISO_MODE_BIT = 4; // MISO output mode
    localparam int ADAPT_OFF_BIT = 0; // Adaptation bypass
    localparam int LOWER_LSB = 1; // Manual lower bits
    localparam int UPPER_LSB = 5; // Manual upper bits
    localparam int MAN_W = 3; // Each manual half
    localparam int FLOOR_LSB = 0; // Start floor low bit
    localparam int FLOOR_W = 4; // Start floor width
    localparam int EQ_W = 6; // Equalizer setting width
    localparam int LT_SEL_BIT = 7; // Loop-through input select
    localparam int LT_EN_BIT = 3; // Loop-through driver enable
    localparam int FAULT_MASK_W = 5; // Writable bits of threshold register

    // Back-channel kinds
    typedef enum logic [2:0] {
        BC_GPIO_NORMAL = 3'b000,
        BC_GPIO_HS1 = 3'b001,
        BC_GPIO_HS2 = 3'b010,
        BC_GPIO_HS4 = 3'b011,
        BC_SPI_FWD_NORMAL = 3'b100,
        BC_SPI_FWD_HS = 3'b101,
        BC_RESERVED = 3'b110,
        BC_SPI_REV_HS = 3'b111
    } srx_kind_t;

    // One register access from the control port
    typedef struct packed {
        logic wr; // Write strobe
        logic rd; // Read strobe
        logic [7:0] addr; // Register offset
        logic [7:0] wdata; // Write data
    } srx_req_t;
endpackage

// [design/srx_err_monitor.sv]
// Link integrity error counter for one receive port.
// Assumes error flags are synchronous to clock_in and qualified by a pixel tick.
`timescale 1ns/100ps
module srx_err_monitor (
    input wire logic clock_in, // System clock
    input wire logic reset_in, // Synchronous reset, active high
    input wire logic ce_in, // Clock enable
    input wire logic pix_tick_in, // Pixel clock tick
    input wire logic [2:0] err_in, // Clock0, clock1, data channel errors
    input wire logic count_en_in, // Error counting enabled
    input wire logic [3:0] thr_in, // Error threshold
    input wire logic relock_in, // Lock reacquired, clear state
    output logic lock_lost_out // Lock dropped
);
    logic [3:0] count_r; // Errors seen so far
    logic [3:0] count_nxt; // Count including this tick
    logic hit; // Any channel in error this tick

    // Any monitored channel flags an error on a pixel tick
    assign hit = pix_tick_in && (|err_in); // RL3
    assign count_nxt = count_r + 4'h1;

    // Error counter, advances only on pixel ticks
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            count_r <= 4'h0;
        end else if (ce_in) begin
            if (relock_in) begin
                count_r <= 4'h0;
            end else if (hit && count_en_in && !lock_lost_out) begin
                count_r <= count_nxt; // RL3
            end
        end
    end

    // Lock loss decision
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            lock_lost_out <= 1'b0;
        end else if (ce_in) begin
            if (hit && !count_en_in) begin
                lock_lost_out <= 1'b1; // RL2
            end else if (hit && count_en_in && count_nxt >= thr_in) begin
                lock_lost_out <= 1'b1; // RL1
            end else if (relock_in) begin
                lock_lost_out <= 1'b0;
            end
        end
    end

    thr_reach_a: assert property (@(posedge clock_in) disable iff (reset_in)
        ce_in && hit && count_en_in && (count_r + 4'h1 >= thr_in) |=> lock_lost_out) // RL1
        else $error("lock not lost at threshold");
    first_err_a: assert property (@(posedge clock_in) disable iff (reset_in)
        ce_in && hit && !count_en_in |=> lock_lost_out) // RL2
        else $error("lock not lost on first error");
    below_thr_a: assert property (@(posedge clock_in) disable iff (reset_in)
        ce_in && !relock_in && hit && count_en_in && !lock_lost_out
        && (count_r + 4'h1 < thr_in) |=> !lock_lost_out) // RL1
        else $error("lock lost below threshold");
    lock_loss_c: cover property (@(posedge clock_in) disable iff (reset_in)
        count_en_in && $rose(lock_lost_out));
endmodule

// [design/srx_regs.sv]
// Control register slice of a serial video link receiver, two receive ports.
// Assumes the control port delivers one-cycle write/read strobes on clock_in,
// and port select and floor control bits come from registers kept elsewhere.
//
// Contract
// RL1: Counted mode drops lock at threshold count
// RL2: Uncounted mode drops lock on first error
// RL3: Counter on pixel tick, watches three channels
// RL4: Reverse SPI mode may float MISO unselected
// RL5: Polarity picks drive and sample edges
// RL6: Kinds 000-011 select GPIO back-channel modes
// RL7: Kinds 100,101,111 select SPI back-channel modes
// RL8: Bypass bit set disables adaptive equalizer
// RL9: Manual setting joins upper and lower halves
// RL10: Adaptation starts from floor value
// RL11: Port select steers floor writes
// RL12: Select bit picks loop-through source input
// RL13: Loop-through driver off until enabled
// RL14: Software keeps source select consistent elsewhere
// RL15: Port select steers writes and reads
// RL16: Floor needs apply and override bits
// RL17: Reserved kind keeps previous mode
`timescale 1ns/100ps
module srx_regs (
    input wire logic clock_in, // System clock, 250 MHz
    input wire logic reset_in, // Synchronous reset, active high
    input wire logic ce_in, // Clock enable, freezes state when low
    input wire srx_pkg::srx_req_t req_in, // Register access request
    output logic [7:0] rdata_out, // Read data, registered
    output logic rvalid_out, // Read data valid pulse
    input wire logic port0_sel_in, // First port selected for access
    input wire logic second_port_register_select_in, // Second port selected for access
    input wire logic floor_apply_in, // Floor apply control bit
    input wire logic floor_override_in, // Floor override control bit
    input wire logic [11:0] eq_state_in, // Adaptive state, port1 high half
    input wire logic pix_tick_in, // Pixel clock tick
    input wire logic [5:0] link_err_in, // Errors, port1 in high three
    input wire logic [1:0] relock_in, // Lock reacquired per port
    output logic [1:0] lock_lost_out, // Lock dropped per port
    output logic [1:0] adapt_off_out, // Adaptation bypassed per port
    output logic [11:0] eq_manual_out, // Manual setting, port1 high half
    output logic [7:0] eq_floor_out, // Effective start floor per port
    output logic [2:0] bc_kind_out, // Active back-channel kind
    output logic [2:0] gpio_count_out, // High-speed GPIO count, 0 if none
    output logic bc_spi_out, // Back-channel carries SPI
    output logic bc_high_speed_out, // Back-channel high speed
    output logic bc_reverse_out, // Reverse channel SPI
    input wire logic spi_clk_in, // Serial clock, sampled
    input wire logic spi_ss_n_in, // Slave select, active low
    input wire logic miso_data_in, // Data to send on MISO
    output logic miso_out, // MISO output value
    output logic miso_oe_out, // MISO output enable
    output logic spi_drive_out, // Drive edge pulse
    output logic spi_sample_out, // Sample edge pulse
    input wire logic [1:0] fwd_data_in, // Recovered forward data per input
    output logic lt_data_out, // Loop-through data
    output logic lt_enable_out // Loop-through driver enabled
);
    logic [7:0] thr_r [2]; // Fault threshold per port
    logic [7:0] manual_r [2]; // Manual setting per port
    logic [7:0] floor_r [2]; // Floor config per port
    logic [7:0] back_cfg_r; // Shared back-channel config
    logic [7:0] lt_src_r; // Shared loop-through source
    logic [7:0] lt_drv_r; // Shared loop-through driver
    srx_pkg::srx_kind_t kind_r; // Active back-channel kind
    logic [5:0] mode_r; // Decoded {gpio count, spi, high speed, reverse}
    logic [1:0] wr_port; // Port copies written this access
    logic rd_port; // Port copy read
    logic spi_clk_r; // Previous serial clock
    logic rise; // Serial clock rising
    logic fall; // Serial clock falling

    // Is a written value a recognised kind
    function automatic logic kind_ok(input logic [2:0] k);
        kind_ok = (k != srx_pkg::BC_RESERVED);
    endfunction

    // Port steering of writes and reads
    assign wr_port = {second_port_register_select_in, port0_sel_in}; // RL15
    assign rd_port = second_port_register_select_in; // RL15

    // Per-port registers and error monitors
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            // Per-port register copies
            always_ff @(posedge clock_in) begin
                if (reset_in) begin
                    thr_r[p] <= srx_pkg::FAULT_THR_RST;
                    manual_r[p] <= srx_pkg::EQ_MANUAL_RST;
                    floor_r[p] <= srx_pkg::EQ_FLOOR_RST;
                end else if (ce_in && req_in.wr && wr_port[p]) begin
                    if (req_in.addr == srx_pkg::FAULT_THR_ADDR) begin
                        thr_r[p] <= {3'h0, req_in.wdata[srx_pkg::FAULT_MASK_W-1:0]};
                    end else if (req_in.addr == srx_pkg::EQ_MANUAL_ADDR) begin
                        manual_r[p] <= req_in.wdata;
                    end else if (req_in.addr == srx_pkg::EQ_FLOOR_ADDR) begin
                        floor_r[p] <= req_in.wdata; // RL11
                    end
                end
            end

            // Link error counting for this port
            srx_err_monitor u_err (
                .clock_in(clock_in),
                .reset_in(reset_in),
                .ce_in(ce_in),
                .pix_tick_in(pix_tick_in),
                .err_in(link_err_in[p*3 +: 3]),
                .count_en_in(thr_r[p][srx_pkg::CNT_EN_BIT]),
                .thr_in(thr_r[p][srx_pkg::THR_LSB +: srx_pkg::THR_W]),
                .relock_in(relock_in[p]),
                .lock_lost_out(lock_lost_out[p])
            );

            // Equalizer controls, registered
            always_ff @(posedge clock_in) begin
                if (reset_in) begin
                    adapt_off_out[p] <= 1'b0;
                    eq_manual_out[p*6 +: 6] <= 6'h18;
                    eq_floor_out[p*4 +: 4] <= 4'h0;
                end else if (ce_in) begin
                    adapt_off_out[p] <= manual_r[p][srx_pkg::ADAPT_OFF_BIT]; // RL8
                    eq_manual_out[p*6 +: 6] <= {
                        manual_r[p][srx_pkg::UPPER_LSB +: srx_pkg::MAN_W],
                        manual_r[p][srx_pkg::LOWER_LSB +: srx_pkg::MAN_W]}; // RL9
                    if (floor_apply_in && floor_override_in) begin
                        eq_floor_out[p*4 +: 4] <=
                            floor_r[p][srx_pkg::FLOOR_LSB +: srx_pkg::FLOOR_W]; // RL10 RL16
                    end else begin
                        eq_floor_out[p*4 +: 4] <= 4'h0; // RL16
                    end
                end
            end
        end
    endgenerate

    // Shared registers
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            back_cfg_r <= srx_pkg::BACK_CFG_RST;
            lt_src_r <= srx_pkg::LT_SOURCE_RST;
            lt_drv_r <= srx_pkg::LT_DRIVER_RST;
        end else if (ce_in && req_in.wr && (|wr_port)) begin
            if (req_in.addr == srx_pkg::BACK_CFG_ADDR) begin
                back_cfg_r <= req_in.wdata;
            end else if (req_in.addr == srx_pkg::LT_SOURCE_ADDR) begin
                lt_src_r <= req_in.wdata;
            end else if (req_in.addr == srx_pkg::LT_DRIVER_ADDR) begin
                lt_drv_r <= req_in.wdata;
            end
        end
    end

    // Active kind, reserved code keeps the previous one
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            kind_r <= srx_pkg::BC_GPIO_NORMAL;
        end else if (ce_in && kind_ok(back_cfg_r[srx_pkg::KIND_LSB +: srx_pkg::KIND_W])) begin
            kind_r <= srx_pkg::srx_kind_t'(back_cfg_r[srx_pkg::KIND_LSB +: srx_pkg::KIND_W]); // RL17
        end
    end

    // Back-channel mode decode, low three bits are {spi, high speed, reverse}
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            mode_r <= 6'h00;
        end else if (ce_in) begin
            case (kind_r)
                srx_pkg::BC_GPIO_HS1: mode_r <= {3'h1, 3'h2}; // RL6
                srx_pkg::BC_GPIO_HS2: mode_r <= {3'h2, 3'h2}; // RL6
                srx_pkg::BC_GPIO_HS4: mode_r <= {3'h4, 3'h2}; // RL6
                srx_pkg::BC_SPI_FWD_NORMAL: mode_r <= {3'h0, 3'h4}; // RL7
                srx_pkg::BC_SPI_FWD_HS: mode_r <= {3'h0, 3'h6}; // RL7
                srx_pkg::BC_SPI_REV_HS: mode_r <= {3'h0, 3'h7}; // RL7
                default: mode_r <= 6'h00; // RL6
            endcase
        end
    end
    assign {gpio_count_out, bc_spi_out, bc_high_speed_out, bc_reverse_out} = mode_r;
    assign bc_kind_out = kind_r;

    // Serial clock edge detection
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            spi_clk_r <= spi_clk_in; // Track idle level, no false edge
        end else if (ce_in) begin
            spi_clk_r <= spi_clk_in;
        end
    end
    assign rise = ce_in && spi_clk_in && !spi_clk_r;
    assign fall = ce_in && !spi_clk_in && spi_clk_r;
    // Polarity 0 drives on falling, samples on rising
    assign spi_drive_out = back_cfg_r[srx_pkg::POL_BIT] ? rise : fall; // RL5
    assign spi_sample_out = back_cfg_r[srx_pkg::POL_BIT] ? fall : rise; // RL5

    // MISO driver, launched on the drive edge
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            miso_out <= 1'b0;
        end else if (spi_drive_out) begin
            miso_out <= miso_data_in; // RL5
        end
    end
    assign miso_oe_out = bc_reverse_out
        && (!back_cfg_r[srx_pkg::MISO_MODE_BIT] || !spi_ss_n_in); // RL4

    // Loop-through output
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            lt_data_out <= 1'b0;
            lt_enable_out <= 1'b0;
        end else if (ce_in) begin
            lt_enable_out <= lt_drv_r[srx_pkg::LT_EN_BIT]; // RL13
            if (lt_drv_r[srx_pkg::LT_EN_BIT]) begin
                lt_data_out <= fwd_data_in[lt_src_r[srx_pkg::LT_SEL_BIT]]; // RL12
            end else begin
                lt_data_out <= 1'b0; // RL13
            end
        end
    end

    // Register read-back
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
            rvalid_out <= 1'b0;
        end else if (ce_in) begin
            rvalid_out <= req_in.rd;
            if (req_in.rd) begin
                if (req_in.addr == srx_pkg::EQ_READOUT_ADDR) begin
                    rdata_out <= {2'h0, eq_state_in[rd_port*6 +: 6]}; // RL15
                end else if (req_in.addr == srx_pkg::FAULT_THR_ADDR) begin
                    rdata_out <= thr_r[rd_port];
                end else if (req_in.addr == srx_pkg::BACK_CFG_ADDR) begin
                    rdata_out <= back_cfg_r;
                end else if (req_in.addr == srx_pkg::EQ_MANUAL_ADDR) begin
                    rdata_out <= manual_r[rd_port];
                end else if (req_in.addr == srx_pkg::EQ_FLOOR_ADDR) begin
                    rdata_out <= floor_r[rd_port];
                end else if (req_in.addr == srx_pkg::LT_SOURCE_ADDR) begin
                    rdata_out <= lt_src_r;
                end else if (req_in.addr == srx_pkg::LT_DRIVER_ADDR) begin
                    rdata_out <= lt_drv_r;
                end else begin
                    rdata_out <= 8'h00;
                end
            end
        end
    end

    miso_float_a: assert property (@(posedge clock_in) disable iff (reset_in)
        bc_reverse_out && back_cfg_r[srx_pkg::MISO_MODE_BIT] && spi_ss_n_in
        |-> !miso_oe_out) // RL4
        else $error("MISO driven while unselected");
    miso_drive_a: assert property (@(posedge clock_in) disable iff (reset_in)
        bc_reverse_out && !back_cfg_r[srx_pkg::MISO_MODE_BIT] |-> miso_oe_out) // RL4
        else $error("MISO not driven in always mode");
    drive_edge_a: assert property (@(posedge clock_in) disable iff (reset_in)
        spi_drive_out |-> (back_cfg_r[srx_pkg::POL_BIT] ? $rose(spi_clk_in)
        : $fell(spi_clk_in))) // RL5
        else $error("drive edge wrong for polarity");
    rev_kind_a: assert property (@(posedge clock_in) disable iff (reset_in)
        ce_in && kind_r == srx_pkg::BC_SPI_REV_HS |=> bc_reverse_out && bc_spi_out) // RL7
        else $error("reverse SPI kind not decoded");
    gpio_four_a: assert property (@(posedge clock_in) disable iff (reset_in)
        ce_in && kind_r == srx_pkg::BC_GPIO_HS4 |=> gpio_count_out == 3'h4) // RL6
        else $error("four GPIO kind not decoded");
    reserved_hold_a: assert property (@(posedge clock_in) disable iff (reset_in)
        back_cfg_r[2:0] == 3'b110 |=> kind_r == $past(kind_r)) // RL17
        else $error("reserved kind changed mode");
    floor_gate_a: assert property (@(posedge clock_in) disable iff (reset_in)
        ce_in && !(floor_apply_in && floor_override_in) |=> eq_floor_out[3:0] == 4'h0) // RL16
        else $error("floor applied without permission");
    manual_join_a: assert property (@(posedge clock_in) disable iff (reset_in)
        ce_in |=> eq_manual_out[5:0] == {$past(manual_r[0][7:5]), $past(manual_r[0][3:1])}) // RL9
        else $error("manual setting halves misplaced");
    lt_off_a: assert property (@(posedge clock_in) disable iff (reset_in)
        !lt_enable_out |-> !lt_data_out) // RL13
        else $error("loop-through active while disabled");
    lt_src_a: assert property (@(posedge clock_in) disable iff (reset_in)
        ce_in && lt_drv_r[3] |=> lt_data_out == $past(fwd_data_in[lt_src_r[7]])) // RL12
        else $error("loop-through source wrong");
    floor_port_a: assert property (@(posedge clock_in) disable iff (reset_in)
        ce_in && req_in.wr && second_port_register_select_in && !port0_sel_in
        && req_in.addr == srx_pkg::EQ_FLOOR_ADDR |=> floor_r[1] == $past(req_in.wdata)
        && floor_r[0] == $past(floor_r[0])) // RL11
        else $error("floor write not steered to second port");
    bypass_a: assert property (@(posedge clock_in) disable iff (reset_in)
        ce_in |=> adapt_off_out[0] == $past(manual_r[0][0])) // RL8
        else $error("bypass bit not followed");
    rev_spi_c: cover property (@(posedge clock_in) disable iff (reset_in)
        bc_reverse_out && miso_oe_out);
    lt_on_c: cover property (@(posedge clock_in) disable iff (reset_in)
        $rose(lt_enable_out));
    port1_rd_c: cover property (@(posedge clock_in) disable iff (reset_in)
        req_in.rd && second_port_register_select_in);
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the link receiver control register slice.
// Assumes srx_regs from design/ and srx_pkg from common/; one 250 MHz clock.
`timescale 1ns/100ps
module testbench;
    logic clock_in, reset_in, ce_in, port0_sel_in, second_port_register_select_in, pix_tick_in; // Stimulus
    logic floor_apply_in, floor_override_in, spi_clk_in, spi_ss_n_in, miso_data_in; // Stimulus
    srx_pkg::srx_req_t req_in; // Register request
    logic [11:0] eq_state_in; // Adaptive state
    logic [5:0] link_err_in; // Link errors
    logic [1:0] relock_in, fwd_data_in, lock_lost_out, adapt_off_out; // Per port
    logic [7:0] rdata_out, eq_floor_out; // Read data, floors
    logic [11:0] eq_manual_out; // Manual settings
    logic [2:0] bc_kind_out, gpio_count_out; // Back-channel decode
    logic rvalid_out, bc_spi_out, bc_high_speed_out, bc_reverse_out, miso_out, miso_oe_out;
    logic spi_drive_out, spi_sample_out, lt_data_out, lt_enable_out; // Other outputs
    int fail_count = 0; // Mismatches
    int checks_done = 0; // Comparisons
    logic [5:0] kind_exp [8] = '{6'h00, 6'h0a, 6'h12, 6'h22, 6'h04, 6'h06, 6'h06, 6'h07};

    srx_regs dut_u (.*);

    // Free-running clock
    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    // Compare seen against expected
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        req_in <= {1'b1, 1'b0, a, d};
        @(posedge clock_in);
        req_in <= '0;
    endtask

    // One register read, answer one cycle after the request
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in);
        req_in <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clock_in);
        req_in <= '0;
        #1 chk({11'h000, rvalid_out}, 12'h001);
        d = rdata_out;
    endtask

    // Idle cycles, then settle
    task automatic idle(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    // Pixel tick with errors on port0
    task automatic tick(input logic [2:0] e);
        @(posedge clock_in);
        pix_tick_in <= 1'b1;
        link_err_in <= {3'b000, e};
        @(posedge clock_in);
        pix_tick_in <= 1'b0;
        link_err_in <= '0;
        idle(1);
    endtask

    // Reset values, read-only status, unmapped read
    task automatic sc_reset_regs();
        logic [7:0] d;
        logic [7:0] addrs [7] = '{8'h41, 8'h43, 8'h44, 8'h45, 8'h52, 8'h56, 8'h77};
        logic [7:0] vals [7] = '{8'h03, 8'h00, 8'h60, 8'h88, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 7; i++) begin
            rd(addrs[i], d);
            chk(d, vals[i]);
        end
        chk(eq_manual_out, 12'h618);
        wr(8'h3b, 8'hff);
        rd(8'h3b, d);
        chk(d, 8'h25);
    endtask

    // Counted and uncounted lock loss with relock
    task automatic sc_errors();
        wr(8'h41, 8'h13);
        tick(3'b001);
        tick(3'b110);
        chk(lock_lost_out, 2'b00);
        tick(3'b100);
        chk(lock_lost_out, 2'b01);
        @(posedge clock_in) relock_in <= 2'b01;
        @(posedge clock_in) relock_in <= 2'b00;
        wr(8'h41, 8'h03);
        chk(lock_lost_out, 2'b00);
        tick(3'b010);
        chk(lock_lost_out, 2'b01);
    endtask

    // Every back-channel kind including the reserved code, then MISO floating while unselected
    task automatic sc_kinds();
        for (int k = 0; k < 8; k++) begin
            wr(8'h43, 8'(k));
            idle(4);
            chk({bc_kind_out, gpio_count_out, bc_spi_out, bc_high_speed_out, bc_reverse_out},
                {(k == 6) ? 3'h5 : 3'(k), kind_exp[k]});
        end
        wr(8'h43, 8'h17);
        idle(4);
        chk(miso_oe_out, 1'b0);
        @(posedge clock_in) spi_ss_n_in <= 1'b0;
        idle(1);
        chk(miso_oe_out, 1'b1);
    endtask

    // Serial clock edges and MISO launch edge for both polarities
    task automatic sc_spi_edges();
        for (int pol = 0; pol < 2; pol++) begin
            wr(8'h43, pol ? 8'h1f : 8'h17);
            @(posedge clock_in) {spi_clk_in, miso_data_in} <= 2'b10;
            #1 chk({spi_drive_out, spi_sample_out}, pol ? 2'b10 : 2'b01);
            @(posedge clock_in) {spi_clk_in, miso_data_in} <= 2'b01;
            #1 chk({spi_drive_out, spi_sample_out}, pol ? 2'b01 : 2'b10);
            idle(1);
            chk(miso_out, 1'(pol == 0));
        end
    endtask

    // Manual setting, port-steered floor, loop-through
    task automatic sc_eq_lt();
        logic [7:0] d;
        wr(8'h44, 8'ha5);
        idle(2);
        chk({adapt_off_out[0], eq_manual_out[5:0]}, 7'h6a);
        @(posedge clock_in) {second_port_register_select_in, port0_sel_in} <= 2'b10;
        wr(8'h45, 8'h05);
        rd(8'h45, d);
        chk(d, 8'h05);
        @(posedge clock_in) {second_port_register_select_in, port0_sel_in} <= 2'b01;
        rd(8'h45, d);
        chk(d, 8'h88);
        chk(eq_floor_out, 8'h00);
        @(posedge clock_in) {floor_apply_in, floor_override_in} <= 2'b11;
        idle(2);
        chk(eq_floor_out, 8'h58);
        chk({lt_enable_out, lt_data_out}, 2'b00);
        wr(8'h56, 8'h08);
        idle(2);
        chk({lt_enable_out, lt_data_out}, 2'b10);
        wr(8'h52, 8'h80);
        idle(2);
        chk({lt_enable_out, lt_data_out}, 2'b11);
    endtask

    // Counts and verdict
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        {reset_in, ce_in, port0_sel_in} = 3'b111;
        {second_port_register_select_in, pix_tick_in, floor_apply_in, floor_override_in} = '0;
        {spi_clk_in, spi_ss_n_in, miso_data_in, relock_in} = 5'b01000;
        {req_in, link_err_in, fwd_data_in} = 26'h2; // Input 1 carries a one, input 0 a zero
        eq_state_in = 12'h9a5;
        repeat (8) @(posedge clock_in);
        reset_in <= 1'b0;
        sc_reset_regs();
        sc_errors();
        sc_kinds();
        sc_spi_edges();
        sc_eq_lt();
        report_and_stop();
    end
endmodule
